// ---- tcp_defines.svh ----
// timer compare pwm channel: offsets, field positions, reset values, action pattern and axi responses
`ifndef TCP_DEFINES_SVH
`define TCP_DEFINES_SVH

// register byte offsets on the axi4-lite bus
`define TCP_OFF_CTRL    12'h000
`define TCP_OFF_TOP     12'h004
`define TCP_OFF_CMP     12'h008
`define TCP_OFF_COUNT   12'h00c
`define TCP_OFF_STATUS  12'h010
`define TCP_OFF_MASK    12'h014
`define TCP_OFF_ACTIVE  12'h018

// control register field positions
`define TCP_CTRL_RUN     0
`define TCP_CTRL_CMODE   1
`define TCP_CTRL_ACT_LO  2
`define TCP_CTRL_ACT_HI  4
`define TCP_CTRL_CMF_LO  5
`define TCP_CTRL_CMF_HI  6
`define TCP_CTRL_INV     7
`define TCP_CTRL_TRIG    8
`define TCP_CTRL_PS_LO   12
`define TCP_CTRL_PS_HI   15

// status bits
`define TCP_ST_OVF  0
`define TCP_ST_CMP  1

// reset values
`define TCP_CTRL_RST   32'h0000_0000
`define TCP_TOP_RST    16'hffff
`define TCP_CMP_RST    16'h0000
`define TCP_MIN        16'h0000

// pwm action field pattern 10x, low bit ignored
`define TCP_ACT_PWM    2'b10
// axi responses
`define TCP_RESP_OKAY   2'b00
`define TCP_RESP_SLVERR 2'b10

`endif

// ---- tcp_pkg.sv ----
// timer compare pwm channel: shared types
package tcp_pkg;
   // count-mode field values
   typedef enum logic [1:0] {
      TCP_CM_AUTO = 2'b00,
      TCP_CM_EDGE = 2'b01,
      TCP_CM_PFC = 2'b10,
      TCP_CM_PC = 2'b11
   } tcp_cmode_t;
   // count direction, gray along up then down
   typedef enum logic {
      TCP_DIR_UP = 1'b0,
      TCP_DIR_DOWN = 1'b1
   } tcp_dir_t;
endpackage : tcp_pkg

// ---- tcp_channel.sv ----
// timer compare pwm channel with 16-bit timer and axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "tcp_defines.svh"

// How it works
// - compare works in every timer count mode
// - action only when compare within counted range
// - pwm when mode select 1, action 10x
// - compare value double-buffered, loads at update
// - polarity selectable, normal or inverted
// - count mode picks edge or centre aligned
// - resolution follows top, 2 to 16 bits
// - centre mode counts up, down; centred on top
// - top reload buffered, takes effect at underflow or edge wrap
// - centre frequency clock over 2*top*(ps+1)
// - duty cmp/top centre, cmp/(top+1) edge; inverted the remainder of the period
// - cmp at or above top: constant level
// - cmp zero: constant opposite level
// - mode 10 loads and flags underflow only
// - mode 11 loads and flags underflow and top
module tcp_channel (
   input wire logic ref_clk,
   input wire logic rst,
   // axi4-lite write address
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // channel output pin and interrupt
   output logic pwmOut,
   output logic irq
);
   import tcp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [31:0] ctrl_q;        // control bits
   logic [15:0] topBuf_q;      // top value written by software
   logic [15:0] topAct_q;      // top value in use
   logic [15:0] cmpBuf_q;      // compare value written by software
   logic [15:0] cmpAct_q;      // compare value in use
   logic [15:0] count_q;       // timer count
   logic [3:0] psCnt_q;        // prescaler counter
   tcp_dir_t dir_q;            // count direction in centre modes
   logic [1:0] status_q;       // sticky event bits
   logic [1:0] mask_q;         // interrupt mask
   logic pwm_q;                // output flop

   // bus handshake state
   logic awHeld_q;             // write address captured
   logic wHeld_q;              // write data captured
   logic [11:0] awAddr_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;
   logic bValid_q;
   logic rValid_q;
   logic [31:0] rData_q;
   logic [1:0] rResp_q;
   logic [1:0] bResp_q;

   // control field decode
   logic run;
   logic cmpMode;
   logic [2:0] action;
   tcp_cmode_t cmode;
   logic inv;
   logic [3:0] prescale;
   assign run = ctrl_q[`TCP_CTRL_RUN];
   assign cmpMode = ctrl_q[`TCP_CTRL_CMODE];
   assign action = ctrl_q[`TCP_CTRL_ACT_HI:`TCP_CTRL_ACT_LO];
   assign cmode = tcp_cmode_t'(ctrl_q[`TCP_CTRL_CMF_HI:`TCP_CTRL_CMF_LO]);
   assign inv = ctrl_q[`TCP_CTRL_INV];
   assign prescale = ctrl_q[`TCP_CTRL_PS_HI:`TCP_CTRL_PS_LO];

   // merge a bus word into a 32-bit register under byte strobes
   function automatic logic [31:0] mergeStrb(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res;
   endfunction : mergeStrb

   ////////////////////////////////////////////////////////////////////////////
   // timer engine
   logic tick;           // prescaled count enable
   logic centre;         // symmetric mode selected
   logic pwmOn;          // channel in pwm operation
   logic atTop;
   logic atOne;          // last down step before the minimum
   logic centreHigh;     // centre mode level before polarity
   logic wrapEdge;       // edge mode wrap from top to min
   logic underflow;      // centre mode reaches min going down
   logic topTurn;        // centre mode turns at top
   logic cmpLoad;        // compare double-buffer update point
   logic ovfEvent;       // overflow flag event
   logic cmpHit;         // compare match inside counted range

   assign pwmOn = cmpMode && (action[2:1] == `TCP_ACT_PWM);
   assign centre = cmode[1];
   assign tick = run && (psCnt_q == prescale);
   assign atTop = (count_q >= topAct_q);
   assign atOne = (count_q == 16'h0001);
   assign wrapEdge = tick && !centre && atTop;
   assign topTurn = tick && centre && (dir_q == TCP_DIR_UP) && atTop;
   assign underflow = tick && centre && (dir_q == TCP_DIR_DOWN) && atOne;
   // up-count above top-cmp and down-count at or above it give 2*cmp ticks around top
   assign centreHigh = (dir_q == TCP_DIR_UP) ? (count_q > topAct_q - cmpAct_q)
                                             : (count_q >= topAct_q - cmpAct_q);
   // mode 10 loads only at underflow, mode 11 at both turns
   assign cmpLoad = wrapEdge || underflow || (topTurn && cmode == TCP_CM_PC);
   assign ovfEvent = wrapEdge || underflow || (topTurn && cmode == TCP_CM_PC);
   // a match only exists when the compare value is inside 0..top
   assign cmpHit = tick && (count_q == cmpAct_q) && (cmpAct_q <= topAct_q);

   // prescaler divides the clock into count ticks
   always_ff @(posedge ref_clk) begin
      if (rst || !run || tick) begin
         psCnt_q <= 4'h0;
      end else begin
         psCnt_q <= psCnt_q + 4'h1;
      end
   end

   // counter: edge mode wraps at top, centre mode climbs then falls
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         count_q <= `TCP_MIN;
         dir_q <= TCP_DIR_UP;
      end else if (tick) begin
         if (!centre) begin
            count_q <= atTop ? `TCP_MIN : count_q + 16'h0001;
            dir_q <= TCP_DIR_UP;
         end else if (dir_q == TCP_DIR_UP) begin
            if (atTop) begin
               // turning on the tick that sees top keeps top for a single tick
               dir_q <= TCP_DIR_DOWN;
               count_q <= count_q - 16'h0001;
            end else begin
               count_q <= count_q + 16'h0001;
            end
         end else begin
            count_q <= count_q - 16'h0001;
            if (count_q == 16'h0001) begin
               dir_q <= TCP_DIR_UP;
            end
         end
      end
   end

   // top double buffer: follows while stopped, new period at underflow or edge wrap
   // loading only at a turn means a write never cuts a running period short
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         topAct_q <= `TCP_TOP_RST;
      end else if (!run || wrapEdge || underflow) begin
         topAct_q <= topBuf_q;
      end
   end

   // compare double buffer; outside pwm it follows at once
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cmpAct_q <= `TCP_CMP_RST;
      end else if (!run || !pwmOn || cmpLoad) begin
         cmpAct_q <= cmpBuf_q;
      end
   end

   // output level: edge count below compare or centre decode is high, then polarity applied
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pwm_q <= 1'b0;
      end else if (pwmOn) begin
         if (cmpAct_q >= topAct_q) begin
            pwm_q <= !inv;
         end else if (cmpAct_q == `TCP_MIN) begin
            pwm_q <= inv;
         end else begin
            // edge mode high while count below compare, centre mode as decoded above
            pwm_q <= (centre ? centreHigh : (count_q < cmpAct_q)) ^ inv;
         end
      end else begin
         pwm_q <= inv;
      end
   end
   assign pwmOut = pwm_q;

   ////////////////////////////////////////////////////////////////////////////
   // interrupts: set wins over write-one clear
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         status_q <= 2'b00;
      end else begin
         if (bValid_q == 1'b0 && awHeld_q && wHeld_q && awAddr_q == `TCP_OFF_STATUS
             && wStrb_q[0]) begin
            status_q <= status_q & ~wData_q[1:0];
         end
         if (ovfEvent) begin
            status_q[`TCP_ST_OVF] <= 1'b1;
         end
         if (cmpHit) begin
            status_q[`TCP_ST_CMP] <= 1'b1;
         end
      end
   end
   assign irq = |(status_q & mask_q);

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite write path: address and data taken in either order
   logic doWrite;
   assign doWrite = awHeld_q && wHeld_q && !bValid_q;
   assign s_axi_awready = !awHeld_q;
   assign s_axi_wready = !wHeld_q;

   // capture address and data, release after the response
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         awAddr_q <= 12'h000;
         wData_q <= 32'h0000_0000;
         wStrb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && !awHeld_q) begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !wHeld_q) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (bValid_q && s_axi_bready) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
         end
      end
   end

   // bus word merged into each narrow register; the cut to width is made at the write
   logic [31:0] topMerged;
   logic [31:0] cmpMerged;
   logic [31:0] maskMerged;
   assign topMerged = mergeStrb({16'h0000, topBuf_q}, wData_q, wStrb_q);
   assign cmpMerged = mergeStrb({16'h0000, cmpBuf_q}, wData_q, wStrb_q);
   assign maskMerged = mergeStrb({30'h0, mask_q}, wData_q, wStrb_q);

   // register writes
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl_q <= `TCP_CTRL_RST;
         topBuf_q <= `TCP_TOP_RST;
         cmpBuf_q <= `TCP_CMP_RST;
         mask_q <= 2'b00;
      end else if (doWrite) begin
         case (awAddr_q)
            `TCP_OFF_CTRL: ctrl_q <= mergeStrb(ctrl_q, wData_q, wStrb_q) & 32'h0000_f1ff;
            `TCP_OFF_TOP: topBuf_q <= topMerged[15:0];
            `TCP_OFF_CMP: cmpBuf_q <= cmpMerged[15:0];
            `TCP_OFF_MASK: mask_q <= maskMerged[1:0];
            default: ;
         endcase
      end
   end

   // write response; unmapped or read-only offsets answer slverr
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         bValid_q <= 1'b0;
         bResp_q <= `TCP_RESP_OKAY;
      end else if (doWrite) begin
         bValid_q <= 1'b1;
         case (awAddr_q)
            `TCP_OFF_CTRL, `TCP_OFF_TOP, `TCP_OFF_CMP, `TCP_OFF_STATUS,
            `TCP_OFF_MASK: bResp_q <= `TCP_RESP_OKAY;
            default: bResp_q <= `TCP_RESP_SLVERR;
         endcase
      end else if (s_axi_bready) begin
         bValid_q <= 1'b0;
      end
   end
   assign s_axi_bvalid = bValid_q;
   assign s_axi_bresp = bResp_q;

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite read path: one cycle after the address is taken
   assign s_axi_arready = !rValid_q;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rValid_q <= 1'b0;
         rData_q <= 32'h0000_0000;
         rResp_q <= `TCP_RESP_OKAY;
      end else if (s_axi_arvalid && !rValid_q) begin
         rValid_q <= 1'b1;
         rResp_q <= `TCP_RESP_OKAY;
         case (s_axi_araddr)
            `TCP_OFF_CTRL: rData_q <= ctrl_q;
            `TCP_OFF_TOP: rData_q <= {16'h0000, topBuf_q};
            `TCP_OFF_CMP: rData_q <= {16'h0000, cmpBuf_q};
            `TCP_OFF_COUNT: rData_q <= {15'h0000, dir_q, count_q};
            `TCP_OFF_STATUS: rData_q <= {30'h0, status_q};
            `TCP_OFF_MASK: rData_q <= {30'h0, mask_q};
            `TCP_OFF_ACTIVE: rData_q <= {topAct_q, cmpAct_q};
            default: begin
               rData_q <= 32'h0000_0000;
               rResp_q <= `TCP_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rValid_q <= 1'b0;
      end
   end
   assign s_axi_rvalid = rValid_q;
   assign s_axi_rdata = rData_q;
   assign s_axi_rresp = rResp_q;

endmodule : tcp_channel
`default_nettype wire

// ---- tcp_channel_properties.sv ----
// bus and pin assertions for the timer compare pwm channel
`timescale 1ns/1ps
`default_nettype none
module tcp_channel_properties (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic pwmOut,
   input wire logic irq
);
   import tcp_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   //////////////////////////////////////////////////////////////////////
   // both halves of a write taken at one edge
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // response offered but not yet accepted
   sequence s_b_wait;
      s_axi_bvalid && !s_axi_bready;
   endsequence
   property p_after_reset;
      $past(rst) |-> !s_axi_bvalid && !s_axi_rvalid && !irq && !pwmOut;
   endproperty
   property p_wr_answer;
      s_wr_taken |-> ##[1:2] s_axi_bvalid;
   endproperty
   property p_rd_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   property p_b_hold;
      s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_b_done;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   property p_ar_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   // a second write may not be taken while the first answer is pending
   property p_aw_block;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_after_reset: assert property (p_after_reset) else $error("outputs not idle after reset");
   a_wr_answer: assert property (p_wr_answer) else $error("write response late");
   a_rd_answer: assert property (p_rd_answer) else $error("read data late");
   a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
   a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
   a_b_done: assert property (p_b_done) else $error("write response repeated");
   a_ar_block: assert property (p_ar_block) else $error("read address taken while busy");
   a_aw_block: assert property (p_aw_block) else $error("write taken while busy");
endmodule : tcp_channel_properties
`default_nettype wire

// ---- tcp_pin_load.sv ----
// load on the pwm pin: measures period and high time in clocks
`timescale 1ns/1ps
`default_nettype none
module tcp_pin_load (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic pinLevel,
   output logic [15:0] period_q,
   output logic [15:0] high_q,
   output logic [15:0] rise_q
);
   import tcp_pkg::*;
   logic prev_q; // pin level one clock ago
   logic [15:0] since_q; // clocks since the last rise
   logic [15:0] run_q; // clocks the pin has been high
   //////////////////////////////////////////////////////////////////////
   // period is the clock count between two rising edges
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         prev_q <= 1'b0;
         since_q <= 16'h0000;
         period_q <= 16'h0000;
         rise_q <= 16'h0000;
      end else begin
         prev_q <= pinLevel;
         since_q <= (pinLevel && !prev_q) ? 16'h0001 : since_q + 16'h0001;
         if (pinLevel && !prev_q) begin
            period_q <= since_q;
            rise_q <= rise_q + 16'h0001;
         end
      end
   end
   // high time latched on the fall, so a partial pulse never shows
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         run_q <= 16'h0000;
         high_q <= 16'h0000;
      end else begin
         run_q <= pinLevel ? run_q + 16'h0001 : 16'h0000;
         if (!pinLevel && run_q != 16'h0000) high_q <= run_q;
      end
   end
endmodule : tcp_pin_load
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for the timer compare pwm channel
`timescale 1ns/1ps
`default_nettype none
`include "tcp_defines.svh"
module testbench;
   import tcp_pkg::*;
   logic ref_clk, rst, awValid, wValid, bReady, arValid, rReady;
   logic [11:0] awAddr, arAddr;
   logic [31:0] wData, rData;
   logic awReady, wReady, bValid, arReady, rValid, pwmOut, irq;
   logic [1:0] bResp, rResp;
   logic [15:0] periodQ, highQ, riseCnt;
   int mismatches, check_count, cyc;
   // pwm cases: control, top, period, high clocks; compare 3, or 1 in the last case
   int cCtl [6] = '{32'h33, 32'hb7, 32'h53, 32'hf3, 32'h1053, 32'h33};
   int cTop [6] = '{9, 9, 9, 9, 9, 3};
   int cPer [6] = '{10, 10, 18, 18, 36, 4};
   int cHi [6] = '{3, 7, 6, 12, 12, 1};
   // constant-level cases: control, compare, level
   int kCtl [7] = '{32'h33, 32'h33, 32'hb3, 32'h33, 32'hb3, 32'h31, 32'hb1};
   int kCmp [7] = '{9, 12, 9, 0, 0, 3, 3};
   int kLvl [7] = '{1, 1, 0, 0, 1, 0, 1};
   always #10 ref_clk = ~ref_clk;
   tcp_channel DUT (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awAddr),
      .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
      .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
      .s_axi_rready(rReady), .pwmOut(pwmOut), .irq(irq));
   tcp_pin_load LOAD (.ref_clk(ref_clk), .rst(rst), .pinLevel(pwmOut), .period_q(periodQ),
      .high_q(highQ), .rise_q(riseCnt));
   //////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      check_count++;
      if (s !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic conclude();
      if (mismatches == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : conclude
   // write: both halves offered, each dropped when taken; ready sampled at the half cycle
   task automatic axiWrite(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aD, wD;
      aD = 1'b0;
      wD = 1'b0;
      awAddr <= a;
      wData <= d;
      awValid <= 1'b1;
      wValid <= 1'b1;
      while (!(aD && wD)) begin
         @(negedge ref_clk);
         aD = aD | awReady;
         wD = wD | wReady;
         @(posedge ref_clk);
         if (aD) awValid <= 1'b0;
         if (wD) wValid <= 1'b0;
      end
      do @(negedge ref_clk); while (bValid !== 1'b1);
      @(posedge ref_clk) bReady <= 1'b1;
      @(negedge ref_clk) chk("bresp", er, bResp);
      @(posedge ref_clk) bReady <= 1'b0;
   endtask : axiWrite
   // read: rready comes late so the data must stand meanwhile
   task automatic axiRead(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic tk;
      tk = 1'b0;
      arAddr <= a;
      arValid <= 1'b1;
      while (!tk) begin
         @(negedge ref_clk) tk = arReady;
         @(posedge ref_clk);
      end
      arValid <= 1'b0;
      do @(negedge ref_clk); while (rValid !== 1'b1);
      @(posedge ref_clk) rReady <= 1'b1;
      @(negedge ref_clk);
      chk("rdata", ed, rData);
      chk("rresp", er, rResp);
      @(posedge ref_clk) rReady <= 1'b0;
   endtask : axiRead
   // wait for n rising edges on the pin; the timeout bounds it
   task automatic rises(input int n);
      logic [15:0] r0;
      r0 = riseCnt;
      while (int'(riseCnt - r0) < n) @(posedge ref_clk);
   endtask : rises
   // stop, load top and compare directly, then run; trigger bit kept clear
   task automatic setup(input logic [31:0] c, input logic [15:0] t, input logic [15:0] m);
      axiWrite(`TCP_OFF_CTRL, 32'h0, `TCP_RESP_OKAY);
      axiWrite(`TCP_OFF_TOP, {16'h0, t}, `TCP_RESP_OKAY);
      axiWrite(`TCP_OFF_CMP, {16'h0, m}, `TCP_RESP_OKAY);
      axiWrite(`TCP_OFF_CTRL, c, `TCP_RESP_OKAY);
   endtask : setup
   // hang guard: far above the few thousand clocks the run needs
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 30000) begin
         mismatches++;
         conclude();
      end
   end
   initial begin
      {ref_clk, awValid, wValid, bReady, arValid, rReady} = 6'h00;
      {awAddr, arAddr, wData} = 56'h0;
      rst = 1'b1;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      // reset values, unmapped and read-only places
      axiRead(`TCP_OFF_CTRL, `TCP_CTRL_RST, `TCP_RESP_OKAY);
      axiRead(`TCP_OFF_TOP, {16'h0, `TCP_TOP_RST}, `TCP_RESP_OKAY);
      axiRead(`TCP_OFF_CMP, {16'h0, `TCP_CMP_RST}, `TCP_RESP_OKAY);
      axiRead(12'h020, 32'h0, `TCP_RESP_SLVERR);
      axiWrite(`TCP_OFF_COUNT, 32'h5, `TCP_RESP_SLVERR);
      // edge and centre waveforms, both polarities, prescale, 2-bit period
      for (int i = 0; i < 6; i++) begin
         setup(cCtl[i], cTop[i], 16'd3 - (i == 5 ? 16'd2 : 16'd0));
         rises(3);
         chk("period", cPer[i], periodQ);
         chk("high", cHi[i], highQ);
      end
      // compare at the extremes and outside pwm: the pin never moves
      for (int i = 0; i < 7; i++) begin
         int bad;
         setup(kCtl[i], 16'd9, kCmp[i]);
         axiWrite(`TCP_OFF_STATUS, 32'h3, `TCP_RESP_OKAY); // clear flags of earlier cases
         repeat (4) @(posedge ref_clk);
         bad = 0;
         repeat (40) begin
            @(negedge ref_clk);
            if (pwmOut !== kLvl[i]) bad++;
         end
         @(posedge ref_clk);
         chk("level", 32'h0, bad);
         axiRead(`TCP_OFF_STATUS, (i == 1) ? 32'h1 : 32'h3, `TCP_RESP_OKAY);
      end
      // new top and compare wait for the underflow
      setup(32'h53, 16'd200, 16'd100);
      rises(2);
      axiWrite(`TCP_OFF_TOP, 32'd50, `TCP_RESP_OKAY);
      axiWrite(`TCP_OFF_CMP, 32'd10, `TCP_RESP_OKAY);
      axiRead(`TCP_OFF_ACTIVE, {16'd200, 16'd100}, `TCP_RESP_OKAY);
      rises(3);
      chk("period", 32'd100, periodQ);
      chk("high", 32'd20, highQ);
      // overflow interrupt masked, unmasked, then cleared
      axiWrite(`TCP_OFF_MASK, 32'h0, `TCP_RESP_OKAY);
      chk("irq", 32'h0, irq);
      axiWrite(`TCP_OFF_MASK, 32'h1, `TCP_RESP_OKAY);
      chk("irq", 32'h1, irq);
      axiWrite(`TCP_OFF_CTRL, 32'h0, `TCP_RESP_OKAY);
      axiWrite(`TCP_OFF_STATUS, 32'h3, `TCP_RESP_OKAY);
      chk("irq", 32'h0, irq);
      axiRead(`TCP_OFF_STATUS, 32'h0, `TCP_RESP_OKAY);
      conclude();
   end
endmodule : testbench
bind tcp_channel tcp_channel_properties PROPS (.ref_clk(ref_clk), .rst(rst),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .pwmOut(pwmOut), .irq(irq));
`default_nettype wire
